// *** core/rpm_pkg.sv ***
// shared constants and carriers for the reset and power-mode controller
package rpm_pkg;

	localparam int          RPM_NSRC         = 6;
	// reset source flag positions
	localparam int          SRC_PIN          = 0;
	localparam int          SRC_POR          = 1;
	localparam int          SRC_BOD          = 2;
	localparam int          SRC_WDT          = 3;
	localparam int          SRC_SW           = 4;
	localparam int          SRC_BRK          = 5;
	localparam logic [5:0]  RST_FLAGS_POR    = 6'h06;
	localparam logic [7:0]  BOOT_LOW_BYTE    = 8'h00;
	localparam logic [15:0] RESET_VEC_ZERO   = 16'h0000;
	// reset pulse stretch, in ns, and its cycle count at 25 MHz
	localparam int          RST_HOLD_NS      = 400;
	localparam int          CLK_PERIOD_NS    = 40;
	localparam int          RST_HOLD_CYC     = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		PM_RUN,
		PM_IDLE,
		PM_PD,
		PM_TPD
	} rpm_mode_e;

	typedef struct packed {
		logic pin;
		logic por;
		logic bod;
		logic wdt;
		logic sw;
		logic brk;
	} rpm_src_s;

	typedef struct packed {
		logic osc_run;
		logic rc_osc_run;
		logic bod_pwr;
		logic cmp_pwr;
		logic wdt_run;
		logic systmr_run;
	} rpm_pwr_s;

endpackage : rpm_pkg

// *** core/rpm_ctrl.sv ***
// reset, brownout and power-reduction mode controller
`timescale 1ns/1ns

// Behaviour
// - brownout resets by default; configured otherwise it requests an interrupt instead
// - software enables brownout detection; condition follows supply versus trip level
// - power-on flag set at power-up and held until software clears it
// - idle, power-down, total power-down; idle ends on enabled interrupt or reset
// - power-down stops main oscillator; left on reset or selected interrupts
// - brownout, watchdog, comparators and system timer keep running in power-down
// - RC oscillator stops in power-down unless it clocks system and timer enabled
// - total power-down also disables brownout detection and comparators
// - reset-pin-enable set makes shared pin active-low reset, else digital input
// - during power-up shared pin always resets; no other source overrides
// - six reset sources: pin, power-on, brownout, watchdog, software, serial break
// - each source has a flag; writing zero clears it; several may be set
// - power-on reset sets power-on and brownout flags, clears the others
// - other resets keep uncleared flags and set the new source flag
// - fetch starts at zero or at boot vector high byte with zero low byte
// - boot address after break reset, boot status bit set, or forced programming at power-up
module rpm_ctrl
	import rpm_pkg::*;
#(
	parameter int HOLD_CYC = RST_HOLD_CYC
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        shared_reset_pin_in,
	input  wire logic        reset_pin_enable_in,
	input  wire logic        bod_enable_in,
	input  wire logic        bod_as_irq_in,
	input  wire logic        supply_below_trip_in,
	input  wire logic        wdt_reset_in,
	input  wire logic        sw_reset_in,
	input  wire logic        break_reset_in,
	input  wire logic        flag_wr_in,
	input  wire logic [5:0]  flag_wr_data_in,
	input  wire logic        bod_irq_ack_in,
	input  wire logic        idle_req_in,
	input  wire logic        pd_req_in,
	input  wire logic        tpd_req_in,
	input  wire logic        irq_any_in,
	input  wire logic        irq_wake_in,
	input  wire logic        rc_is_sysclk_in,
	input  wire logic        systmr_en_in,
	input  wire logic        cmp_off_in,
	input  wire logic [7:0]  boot_vector_in,
	input  wire logic        boot_status_bit_in,
	input  wire logic        isp_force_in,
	output logic             cpu_reset_out,
	output logic [5:0]       reset_source_register_out,
	output logic             power_on_flag_out,
	output logic             brownout_flag_out,
	output logic             bod_irq_out,
	output logic             pin_data_out,
	output logic [15:0]      reset_vector_out,
	output logic [1:0]       pm_mode_out,
	output rpm_pwr_s         pwr_out
);

	initial begin
		if (HOLD_CYC < 1 || HOLD_CYC > 255) begin
			$error("rpm_ctrl: HOLD_CYC out of range");
		end
	end

	logic [2:0]  pin_sync_ff;
	logic        pin_lvl_ff;
	logic [2:0]  bod_sync_ff;
	logic        bod_lvl_ff;
	logic        powerup_ff;
	logic [7:0]  hold_cnt_ff;
	logic [5:0]  flags_ff;
	logic        bod_irq_ff;
	logic        boot_sel_ff;
	rpm_mode_e   mode_ff;
	rpm_src_s    src;
	logic        any_reset;
	logic        bod_cond;
	logic        pin_reset;
	logic [5:0]  nxt_flags;
	rpm_mode_e   nxt_mode;

	// pin and supply comparator come from outside the clock domain
	always_ff @(posedge clk_sys_in) begin
		pin_sync_ff <= {pin_sync_ff[1:0], shared_reset_pin_in};
		bod_sync_ff <= {bod_sync_ff[1:0], supply_below_trip_in};
		if (rst_in) begin
			pin_lvl_ff <= 1'b1;
			bod_lvl_ff <= 1'b0;
		end else begin
			if (pin_sync_ff[1] == pin_sync_ff[2]) begin
				pin_lvl_ff <= pin_sync_ff[2];
			end
			if (bod_sync_ff[1] == bod_sync_ff[2]) begin
				bod_lvl_ff <= bod_sync_ff[2];
			end
		end
	end

	// detector is off when disabled or in total power-down
	assign bod_cond = bod_enable_in && (mode_ff != PM_TPD) && bod_lvl_ff;

	// power-up: pin acts as reset regardless of enable bit
	assign pin_reset = !pin_lvl_ff && (powerup_ff || reset_pin_enable_in);

	always_comb begin
		src.pin = pin_reset;
		src.por = rst_in;
		src.bod = bod_cond && !bod_as_irq_in;
		src.wdt = wdt_reset_in;
		src.sw  = sw_reset_in;
		src.brk = break_reset_in;
	end

	assign any_reset = src.pin | src.bod | src.wdt | src.sw | src.brk;

	// power-up window lasts until the first stretched reset is released
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			powerup_ff <= 1'b1;
		end else if (hold_cnt_ff == 8'h00 && pin_lvl_ff) begin
			powerup_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			hold_cnt_ff <= 8'(HOLD_CYC);
		end else if (any_reset) begin
			hold_cnt_ff <= 8'(HOLD_CYC);
		end else if (hold_cnt_ff != 8'h00) begin
			hold_cnt_ff <= hold_cnt_ff - 8'h01;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cpu_reset_out <= 1'b1;
		end else begin
			cpu_reset_out <= any_reset || hold_cnt_ff != 8'h00 || (powerup_ff && !pin_lvl_ff);
		end
	end

	// source flags: new events win over a software clear
	always_comb begin
		nxt_flags = flags_ff;
		if (flag_wr_in) begin
			nxt_flags = flags_ff & flag_wr_data_in;
		end
		nxt_flags[SRC_PIN] = nxt_flags[SRC_PIN] | src.pin;
		nxt_flags[SRC_BOD] = nxt_flags[SRC_BOD] | src.bod;
		nxt_flags[SRC_WDT] = nxt_flags[SRC_WDT] | src.wdt;
		nxt_flags[SRC_SW]  = nxt_flags[SRC_SW]  | src.sw;
		nxt_flags[SRC_BRK] = nxt_flags[SRC_BRK] | src.brk;
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			flags_ff <= RST_FLAGS_POR;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			bod_irq_ff <= 1'b0;
		end else if (bod_cond && bod_as_irq_in) begin
			bod_irq_ff <= 1'b1;
		end else if (bod_irq_ack_in) begin
			bod_irq_ff <= 1'b0;
		end
	end

	// boot choice is caught on the reset cause
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			boot_sel_ff <= 1'b0;
		end else if (any_reset || powerup_ff) begin
			boot_sel_ff <= src.brk || boot_status_bit_in || (powerup_ff && isp_force_in);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			reset_vector_out <= RESET_VEC_ZERO;
		end else if (boot_sel_ff) begin
			reset_vector_out <= {boot_vector_in, BOOT_LOW_BYTE};
		end else begin
			reset_vector_out <= RESET_VEC_ZERO;
		end
	end

	always_comb begin
		nxt_mode = mode_ff;
		unique case (mode_ff)
			PM_RUN: begin
				if (tpd_req_in) begin
					nxt_mode = PM_TPD;
				end else if (pd_req_in) begin
					nxt_mode = PM_PD;
				end else if (idle_req_in) begin
					nxt_mode = PM_IDLE;
				end
			end
			PM_IDLE: begin
				if (irq_any_in || bod_irq_ff) begin
					nxt_mode = PM_RUN;
				end
			end
			PM_PD,
			PM_TPD: begin
				if (irq_wake_in) begin
					nxt_mode = PM_RUN;
				end
			end
		endcase
		if (any_reset) begin
			nxt_mode = PM_RUN;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			mode_ff <= PM_RUN;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// power enables follow the next mode so they change with it
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			pwr_out <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
		end else begin
			pwr_out.osc_run    <= (nxt_mode == PM_RUN) || (nxt_mode == PM_IDLE);
			pwr_out.rc_osc_run <= (nxt_mode == PM_RUN) || (nxt_mode == PM_IDLE)
			                      || (rc_is_sysclk_in && systmr_en_in);
			pwr_out.bod_pwr    <= bod_enable_in && (nxt_mode != PM_TPD);
			pwr_out.cmp_pwr    <= !cmp_off_in && (nxt_mode != PM_TPD);
			pwr_out.wdt_run    <= 1'b1;
			pwr_out.systmr_run <= systmr_en_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			reset_source_register_out <= RST_FLAGS_POR;
			power_on_flag_out         <= 1'b1;
			brownout_flag_out         <= 1'b1;
			bod_irq_out               <= 1'b0;
			pin_data_out              <= 1'b1;
			pm_mode_out               <= 2'h0;
		end else begin
			reset_source_register_out <= nxt_flags;
			power_on_flag_out         <= nxt_flags[SRC_POR];
			brownout_flag_out         <= nxt_flags[SRC_BOD];
			// same next value as the request flop so the output never lags an ack
			bod_irq_out               <= (bod_cond && bod_as_irq_in)
			                             || (bod_irq_ff && !bod_irq_ack_in);
			pin_data_out              <= pin_lvl_ff;
			pm_mode_out               <= nxt_mode;
		end
	end

endmodule : rpm_ctrl

// *** bench/rpm_props.sv ***
// assertions for the reset and power-mode controller
`timescale 1ns/1ns
module rpm_props
	import rpm_pkg::*;
(
	input wire logic       clk_sys_in,
	input wire logic       rst_in,
	input wire logic       wdt_reset_in,
	input wire logic       flag_wr_in,
	input wire logic [5:0] flag_wr_data_in,
	input wire logic       bod_irq_ack_in,
	input wire logic       irq_any_in,
	input wire logic       irq_wake_in,
	input wire logic       cpu_reset_out,
	input wire logic [5:0] reset_source_register_out,
	input wire logic       bod_irq_out,
	input wire logic [1:0] pm_mode_out,
	input wire rpm_pwr_s   pwr_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	property p_wdt; wdt_reset_in |=> cpu_reset_out && reset_source_register_out[3]; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset lost");
	property p_pof; flag_wr_in && !flag_wr_data_in[1] |=> !reset_source_register_out[1]; endproperty
	a_pof: assert property (p_pof) else $error("power-on flag not cleared");
	property p_keep; reset_source_register_out[3] && !flag_wr_in |=> $stable(reset_source_register_out[3]); endproperty
	a_keep: assert property (p_keep) else $error("flag lost");
	property p_irq; bod_irq_out && !bod_irq_ack_in |=> bod_irq_out; endproperty
	a_irq: assert property (p_irq) else $error("brownout request lost");
	property p_idle; pm_mode_out == PM_IDLE && irq_any_in |=> pm_mode_out == PM_RUN; endproperty
	a_idle: assert property (p_idle) else $error("idle not ended");
	property p_pd; pm_mode_out[1] && irq_wake_in |=> pm_mode_out == PM_RUN; endproperty
	a_pd: assert property (p_pd) else $error("power-down not ended");
	property p_osc; pm_mode_out == PM_PD [*2] |-> !pwr_out.osc_run && pwr_out.wdt_run; endproperty
	a_osc: assert property (p_osc) else $error("power-down supplies wrong");
	property p_tpd; pm_mode_out == PM_TPD [*2] |-> !pwr_out.bod_pwr && !pwr_out.cmp_pwr; endproperty
	a_tpd: assert property (p_tpd) else $error("total power-down supplies wrong");
	cover property (wdt_reset_in ##1 cpu_reset_out);
	cover property (pm_mode_out == PM_PD ##1 pm_mode_out == PM_RUN);
	cover property (pm_mode_out == PM_TPD);
endmodule : rpm_props

bind rpm_ctrl rpm_props rpm_props_i (.clk_sys_in, .rst_in, .wdt_reset_in, .flag_wr_in,
	.flag_wr_data_in, .bod_irq_ack_in, .irq_any_in, .irq_wake_in, .cpu_reset_out,
	.reset_source_register_out, .bod_irq_out, .pm_mode_out, .pwr_out);

// *** bench/rpm_ext_rst.sv ***
// model of the outside reset circuit on the shared pin
`timescale 1ns/1ns
module rpm_ext_rst (
	input  wire logic por_in,
	input  wire logic press_in,
	output logic      pin_out
);
	// pull-up keeps the pin high; never held low during power-on
	assign pin_out = !(press_in && !por_in);
endmodule : rpm_ext_rst

// *** bench/tb.sv ***
// testbench for the reset and power-mode controller
`timescale 1ns/1ns
module tb;
	import rpm_pkg::*;
	logic clk_sys_in = 0, rst_in = 1, press = 0, flag_wr_in = 0, shared_reset_pin_in;
	logic reset_pin_enable_in = 0, bod_enable_in = 0, bod_as_irq_in = 0, cmp_off_in = 0;
	logic supply_below_trip_in = 0, rc_is_sysclk_in = 0, systmr_en_in = 0;
	logic boot_status_bit_in = 0, isp_force_in = 0;
	logic idle_req_in, pd_req_in, tpd_req_in, irq_any_in, irq_wake_in;
	logic wdt_reset_in, sw_reset_in, break_reset_in, bod_irq_ack_in;
	logic [8:0] ev = 9'h000;
	logic [5:0] flag_wr_data_in = 6'h00, reset_source_register_out;
	logic [7:0] boot_vector_in = 8'h5A;
	logic cpu_reset_out, power_on_flag_out, brownout_flag_out, bod_irq_out, pin_data_out;
	logic [15:0] reset_vector_out;
	logic [1:0] pm_mode_out;
	rpm_pwr_s pwr_out;
	int err_total = 0, total_checks = 0;
	assign {idle_req_in, pd_req_in, tpd_req_in, irq_any_in, irq_wake_in, wdt_reset_in,
		sw_reset_in, break_reset_in, bod_irq_ack_in} = ev;
	always #20 clk_sys_in = ~clk_sys_in;
	rpm_ctrl #(.HOLD_CYC(2)) rpm_ctrl_i (.*);
	rpm_ext_rst rpm_ext_rst_i (.por_in(rst_in), .press_in(press), .pin_out(shared_reset_pin_in));
	task tick(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask : tick
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task fire(input int k);
		ev = 9'h001 << k;
		tick(1);
		ev = 9'h000;
		tick(1);
	endtask : fire
	task wr(input logic [5:0] d);
		flag_wr_data_in = d;
		flag_wr_in = 1;
		tick(1);
		flag_wr_in = 0;
		tick(1);
	endtask : wr
	task wait_run;
		int i;
		for (i = 0; i < 60 && cpu_reset_out !== 1'b0; i++) tick(1);
		chk("cpu_reset", 16'h0, cpu_reset_out);
	endtask : wait_run
	task end_of_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	initial begin
		tick(2);
		rst_in = 0;
		wait_run();
		chk("flags", 16'h06, reset_source_register_out);
		chk("pof", 16'h1, power_on_flag_out);
		chk("vec", 16'h0, reset_vector_out);
		fire(3);
		wait_run();
		chk("flags", 16'h0E, reset_source_register_out);
		wr(6'h3D);
		chk("flags", 16'h0C, reset_source_register_out);
		boot_status_bit_in = 1;
		fire(2);
		wait_run();
		chk("vec", 16'h5A00, reset_vector_out);
		boot_status_bit_in = 0;
		fire(1);
		wait_run();
		chk("flags", 16'h3C, reset_source_register_out);
		chk("vec", 16'h5A00, reset_vector_out);
		wr(6'h00);
		bod_enable_in = 1;
		supply_below_trip_in = 1;
		tick(6);
		supply_below_trip_in = 0;
		wait_run();
		chk("bof", 16'h1, brownout_flag_out);
		bod_as_irq_in = 1;
		supply_below_trip_in = 1;
		tick(6);
		supply_below_trip_in = 0;
		chk("cpu_reset", 16'h0, cpu_reset_out);
		chk("irq", 16'h1, bod_irq_out);
		tick(5);
		fire(0);
		chk("irq", 16'h0, bod_irq_out);
		reset_pin_enable_in = 1;
		press = 1;
		tick(6);
		press = 0;
		wait_run();
		chk("flags", 16'h05, reset_source_register_out);
		reset_pin_enable_in = 0;
		press = 1;
		tick(6);
		chk("cpu_reset", 16'h0, cpu_reset_out);
		chk("pin", 16'h0, pin_data_out);
		press = 0;
		fire(8);
		chk("mode", 16'h1, pm_mode_out);
		fire(5);
		chk("mode", 16'h0, pm_mode_out);
		fire(7);
		chk("osc", 16'h0, pwr_out.osc_run);
		fire(5);
		chk("mode", 16'h2, pm_mode_out);
		fire(4);
		chk("mode", 16'h0, pm_mode_out);
		rc_is_sysclk_in = 1;
		systmr_en_in = 1;
		fire(6);
		chk("pwr", 16'h13, pwr_out);
		fire(4);
		fire(8);
		fire(2);
		wait_run();
		chk("mode", 16'h0, pm_mode_out);
		bod_as_irq_in = 0;
		bod_enable_in = 0;
		supply_below_trip_in = 1;
		tick(6);
		chk("cpu_reset", 16'h0, cpu_reset_out);
		chk("flags", 16'h15, reset_source_register_out);
		supply_below_trip_in = 0;
		tick(4);
		end_of_test();
	end
	initial begin
		#400000;
		err_total++;
		end_of_test();
	end
endmodule : tb
